// File: hw/csc_pkg.sv
// package: constants and carrier types for the special address-space cycle logic
//------------------------------------------------------------------------------
// Summary of operation
// - special cycles drive all three space select lines high.
// - cycle type code on address 19..16; only three codes are ever issued.
// - interrupt pending when priority exceeds mask; level 7 pends on transition.
// - pending interrupt starts at next instruction boundary, after higher exceptions.
// - interrupt acknowledge is a read cycle in the special space.
// - acknowledged level on address 3..1, inverted from the priority inputs.
// - interrupt acknowledge carries type code hex F.
// - interrupt acknowledge drives address 31..20, 15..4 and 0 high.
// - autovector ignores data bus; vector equals level plus 24.
// - bus fault on interrupt acknowledge yields spurious vector 24.
// - halt with bus fault on acknowledge retries the cycle.
// - breakpoint cycle uses type code zero, number on address 4..2.
// - normal breakpoint end supplies a word that replaces the breakpoint opcode.
// - breakpoint fetches a whole word; byte port answer needs a second cycle.
// - bus fault on breakpoint acknowledge raises illegal instruction exception.
// - coprocessor access uses type 2, identity on 15..13, register on 4..0.
// - up to seven coprocessors over the ordinary bus protocol.
// - coprocessor interface never issues identity zero; only alternate space move does.
//------------------------------------------------------------------------------
package csc_pkg;

  localparam logic [2:0] SPACE_SPECIAL = 3'h7;
  localparam logic [3:0] TYPE_BREAKPOINT_INSTRUCTION = 4'h0;
  localparam logic [3:0] TYPE_COPROC = 4'h2;
  localparam logic [3:0] TYPE_IACK = 4'hf;
  localparam int TYPE_LSB = 16;
  localparam int LEVEL_LSB = 1;
  localparam int BREAKPOINT_INSTRUCTION_LSB = 2;
  localparam int COPROC_IDENTITY_LSB = 13;
  localparam logic [7:0] AUTOVEC_BASE = 8'h18;
  localparam logic [7:0] SPURIOUS_VEC = 8'h18;
  localparam logic [2:0] NMI_LEVEL = 3'h7;
  // async width answer code: 2'h1 means byte port
  localparam logic [1:0] ACK_BYTE = 2'h1;

  // what the core asks for
  typedef struct packed {
    logic boundary;
    logic higherExc;
    logic [2:0] mask;
    logic bkptGo;
    logic [2:0] bkptNum;
    logic cpGo;
    logic cpWrite;
    logic [2:0] coproc_identity;
    logic [4:0] cpReg;
    logic altMove;
    logic [31:0] cpWdata;
  } csc_req_t;

  // what the far side answers with
  typedef struct packed {
    logic syncEnd;
    logic [1:0] asyncAck;
    logic autovec;
    logic busFault;
    logic halt;
    logic [31:0] data;
  } csc_term_t;

  // bus cycle driven out
  typedef struct packed {
    logic strobe;
    logic write;
    logic [2:0] space;
    logic [31:0] addr;
    logic [31:0] wdata;
  } csc_bus_t;

  // results handed back to the core
  typedef struct packed {
    logic vecValid;
    logic [7:0] vector;
    logic [2:0] level;
    logic wordValid;
    logic [15:0] word;
    logic illegal;
    logic cpDone;
    logic cpFault;
    logic [31:0] cpData;
  } csc_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_IACK = 3'b001,
    ST_BKPT1 = 3'b010,
    ST_BKPT2 = 3'b011,
    ST_COPROC = 3'b100,
    ST_RETRY = 3'b101
  } csc_state_t;

endpackage

// File: hw/csc_irq_sense.sv
// interrupt pending detector with level-7 edge sensing
module csc_irq_sense
  import csc_pkg::*;
(
  input wire logic clock,
  input wire logic rstSync_n,
  input wire logic [2:0] irqPriorityInputs_n,
  input wire logic [2:0] mask,
  input wire logic taken,
  output logic pending,
  output logic [2:0] level
);

  typedef struct packed {
    logic [2:0] lvl;
    logic nmiSeen;
    logic nmiEdge;
  } csc_sense_t;

  csc_sense_t cur;
  csc_sense_t next_cur;

  // inputs are active low: the level is the inverted value
  always_comb begin
    next_cur = cur;
    next_cur.lvl = ~irqPriorityInputs_n;
    next_cur.nmiSeen = (cur.lvl == NMI_LEVEL);
    // level 7 latches on arrival; set wins over the clear from taking it
    if (cur.lvl == NMI_LEVEL && !cur.nmiSeen) begin
      next_cur.nmiEdge = 1'b1;
    end else if (taken) begin
      next_cur.nmiEdge = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // level 7 cannot be masked, but only an edge makes it pend again
  assign pending = (cur.lvl == NMI_LEVEL) ? cur.nmiEdge : (cur.lvl > mask);
  assign level = cur.lvl;

endmodule

// File: hw/csc_cpu_space.sv
// special address-space cycle sequencer: interrupt, breakpoint, coprocessor
module csc_cpu_space
  import csc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] irqPriorityInputs_n,
  input wire csc_pkg::csc_req_t req,
  input wire csc_pkg::csc_term_t term,
  output csc_pkg::csc_bus_t bus,
  output csc_pkg::csc_rsp_t rsp,
  output logic busy
);

  //----------------------------------------------------------------------------
  // reset release
  //----------------------------------------------------------------------------
  logic [1:0] rstPipe;
  logic rstSync_n;

  // async assert, two-flop release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe[1];

  //----------------------------------------------------------------------------
  // interrupt sensing
  //----------------------------------------------------------------------------
  logic irqPending;
  logic [2:0] irqLevel;
  logic irqTaken;

  csc_irq_sense u_sense (
    .clock(clock),
    .rstSync_n(rstSync_n),
    .irqPriorityInputs_n(irqPriorityInputs_n),
    .mask(req.mask),
    .taken(irqTaken),
    .pending(irqPending),
    .level(irqLevel)
  );

  //----------------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------------
  typedef struct packed {
    csc_state_t st;
    csc_bus_t bus;
    csc_rsp_t rsp;
    logic [2:0] ackLevel;
    logic [7:0] hiByte;
  } csc_core_t;

  csc_core_t cur;
  csc_core_t next_cur;

  // address builders, each used at start; the acknowledge one is also used on retry
  function automatic logic [31:0] iackAddr(input logic [2:0] lvl);
    logic [31:0] a;
    a = 32'hffff_ffff;
    a[TYPE_LSB +: 4] = TYPE_IACK;
    a[LEVEL_LSB +: 3] = lvl;
    return a;
  endfunction

  function automatic logic [31:0] bkptAddr(input logic [2:0] num);
    logic [31:0] a;
    a = 32'h0000_0000;
    a[TYPE_LSB +: 4] = TYPE_BREAKPOINT_INSTRUCTION;
    a[BREAKPOINT_INSTRUCTION_LSB +: 3] = num;
    return a;
  endfunction

  function automatic logic [31:0] cpAddr(input logic [2:0] id, input logic [4:0] regSel);
    logic [31:0] a;
    a = 32'h0000_0000;
    a[TYPE_LSB +: 4] = TYPE_COPROC;
    a[COPROC_IDENTITY_LSB +: 3] = id;
    a[4:0] = regSel;
    return a;
  endfunction

  logic normalEnd;
  logic anyEnd;

  // the far side keeps sync and async apart, so either counts as a normal end
  assign normalEnd = term.syncEnd || (term.asyncAck != 2'h0);
  assign anyEnd = normalEnd || term.autovec || term.busFault;
  assign irqTaken = (cur.st == ST_IDLE) && req.boundary && !req.higherExc && irqPending;

  //----------------------------------------------------------------------------
  // sequencer
  //----------------------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.rsp.vecValid = 1'b0;
    next_cur.rsp.wordValid = 1'b0;
    next_cur.rsp.illegal = 1'b0;
    next_cur.rsp.cpDone = 1'b0;
    next_cur.rsp.cpFault = 1'b0;
    unique case (cur.st)
      ST_IDLE: begin
        next_cur.bus = '0;
        // interrupt first, only at a boundary and behind higher exceptions
        if (irqTaken) begin
          next_cur.st = ST_IACK;
          next_cur.ackLevel = irqLevel;
          next_cur.bus.strobe = 1'b1;
          next_cur.bus.write = 1'b0;
          next_cur.bus.space = SPACE_SPECIAL;
          next_cur.bus.addr = iackAddr(irqLevel);
        end else if (req.bkptGo) begin
          next_cur.st = ST_BKPT1;
          next_cur.bus.strobe = 1'b1;
          next_cur.bus.space = SPACE_SPECIAL;
          next_cur.bus.addr = bkptAddr(req.bkptNum);
        end else if (req.cpGo && (req.coproc_identity != 3'h0 || req.altMove)) begin
          next_cur.st = ST_COPROC;
          next_cur.bus.strobe = 1'b1;
          next_cur.bus.write = req.cpWrite;
          next_cur.bus.space = SPACE_SPECIAL;
          next_cur.bus.addr = cpAddr(req.coproc_identity, req.cpReg);
          next_cur.bus.wdata = req.cpWdata;
        end
      end
      ST_IACK: begin
        if (term.busFault && term.halt) begin
          next_cur.st = ST_RETRY;
          next_cur.bus.strobe = 1'b0;
        end else if (anyEnd) begin
          next_cur.st = ST_IDLE;
          next_cur.bus = '0;
          next_cur.rsp.vecValid = 1'b1;
          next_cur.rsp.level = cur.ackLevel;
          if (term.busFault) begin
            next_cur.rsp.vector = SPURIOUS_VEC;
          end else if (term.autovec) begin
            next_cur.rsp.vector = AUTOVEC_BASE + {5'h00, cur.ackLevel};
          end else begin
            next_cur.rsp.vector = term.data[7:0];
          end
        end
      end
      ST_RETRY: begin
        // rerun once halt is released
        if (!term.halt && !term.busFault) begin
          next_cur.st = ST_IACK;
          next_cur.bus.strobe = 1'b1;
          next_cur.bus.addr = iackAddr(cur.ackLevel);
        end
      end
      ST_BKPT1: begin
        if (term.busFault) begin
          next_cur.st = ST_IDLE;
          next_cur.bus = '0;
          next_cur.rsp.illegal = 1'b1;
        end else if (normalEnd && !term.syncEnd && term.asyncAck == ACK_BYTE) begin
          // byte port gave the upper half only; fetch the low byte next
          next_cur.st = ST_BKPT2;
          next_cur.hiByte = term.data[31:24];
          next_cur.bus.addr = cur.bus.addr | 32'h0000_0001;
        end else if (normalEnd) begin
          next_cur.st = ST_IDLE;
          next_cur.bus = '0;
          next_cur.rsp.wordValid = 1'b1;
          next_cur.rsp.word = term.data[31:16];
        end
      end
      ST_BKPT2: begin
        if (term.busFault) begin
          next_cur.st = ST_IDLE;
          next_cur.bus = '0;
          next_cur.rsp.illegal = 1'b1;
        end else if (normalEnd) begin
          next_cur.st = ST_IDLE;
          next_cur.bus = '0;
          next_cur.rsp.wordValid = 1'b1;
          next_cur.rsp.word = {cur.hiByte, term.data[31:24]};
        end
      end
      ST_COPROC: begin
        if (anyEnd) begin
          next_cur.st = ST_IDLE;
          next_cur.bus = '0;
          next_cur.rsp.cpDone = 1'b1;
          next_cur.rsp.cpFault = term.busFault;
          next_cur.rsp.cpData = term.data;
        end
      end
      default: begin
        next_cur.st = ST_IDLE;
        next_cur.bus = '0;
      end
    endcase
  end

  // only three type codes can ever be loaded into the address field
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign bus = cur.bus;
  assign rsp = cur.rsp;
  assign busy = (cur.st != ST_IDLE);

endmodule

// File: tb/csc_cpu_space_assertions.sv
// checker: bus and response timing of the special-space sequencer
module csc_cpu_space_checker
  import csc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] irqPriorityInputs_n,
  input wire csc_pkg::csc_req_t req,
  input wire csc_pkg::csc_term_t term,
  input wire csc_pkg::csc_bus_t bus,
  input wire csc_pkg::csc_rsp_t rsp,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // boundary low keeps an interrupt from taking the request edge
  sequence iackCyc; bus.strobe && bus.addr[19:16] == TYPE_IACK; endsequence
  sequence bkptCyc; bus.strobe && bus.addr[19:16] == TYPE_BREAKPOINT_INSTRUCTION; endsequence
  sequence idleNoIrq; !busy && !req.boundary; endsequence
  AST_SPACE: assert property (bus.strobe |-> bus.space == SPACE_SPECIAL)
    else $error("special cycle outside all-ones space");
  AST_TYPE: assert property (bus.strobe |-> bus.addr[19:16] inside {4'h0, 4'h2, 4'hf})
    else $error("reserved cycle type");
  AST_IACK_ONES: assert property (iackCyc |-> !bus.write && bus.addr[31:20] == 12'hfff
    && bus.addr[15:4] == 12'hfff && bus.addr[0]) else $error("bad acknowledge address");
  AST_AUTOVEC: assert property (iackCyc ##0 (term.autovec && !term.busFault) |=> rsp.vecValid
    && rsp.vector == AUTOVEC_BASE + 8'($past(bus.addr[3:1]))) else $error("bad autovector");
  AST_SPURIOUS: assert property (iackCyc ##0 (term.busFault && !term.halt) |=>
    rsp.vecValid && rsp.vector == SPURIOUS_VEC) else $error("bad spurious vector");
  AST_RETRY: assert property (iackCyc ##0 (term.busFault && term.halt) |=>
    !bus.strobe && !rsp.vecValid) else $error("retry not taken");
  AST_BREAKPOINT_INSTRUCTION_START: assert property (idleNoIrq ##0 req.bkptGo |=> bkptCyc
    ##0 bus.addr[4:2] == $past(req.bkptNum)) else $error("bad breakpoint cycle");
  AST_BREAKPOINT_INSTRUCTION_FAULT: assert property (bkptCyc ##0 term.busFault |=> rsp.illegal)
    else $error("no illegal pulse");
  AST_BREAKPOINT_INSTRUCTION_BYTE: assert property (bkptCyc ##0 (!bus.addr[0] && !term.busFault
    && !term.syncEnd && term.asyncAck == ACK_BYTE) |=> bkptCyc ##0 bus.addr[0] && !rsp.wordValid)
    else $error("no second byte cycle");
  AST_BREAKPOINT_INSTRUCTION_WORD: assert property (bkptCyc ##0 term.syncEnd |=> rsp.wordValid
    && rsp.word == $past(term.data[31:16])) else $error("bad breakpoint word");
  AST_CP_ADDR: assert property (idleNoIrq ##0 (req.cpGo && !req.bkptGo && req.coproc_identity != 3'h0)
    |=> bus.strobe && bus.addr == {12'h0, TYPE_COPROC, $past(req.coproc_identity), 8'h0, $past(req.cpReg)})
    else $error("bad coprocessor address");
  AST_CP_ZERO: assert property (idleNoIrq ##0 (req.cpGo && !req.bkptGo && req.coproc_identity == 3'h0
    && !req.altMove) |=> !bus.strobe) else $error("identity zero issued");
endmodule
bind csc_cpu_space csc_cpu_space_checker csc_cpu_space_checker_inst (.clock(clock),
  .rst_n(rst_n), .irqPriorityInputs_n(irqPriorityInputs_n), .req(req), .term(term),
  .bus(bus), .rsp(rsp), .busy(busy));

// File: tb/csc_far_model.sv
// far-side model: interrupter, debug hardware and coprocessor answers
module csc_far_model
  import csc_pkg::*;
(
  input wire logic clock,
  input wire csc_pkg::csc_bus_t bus,
  input wire logic [2:0] mode,
  input wire logic [31:0] rdata,
  output csc_pkg::csc_term_t term
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h0;
  logic retried = 1'b0;
  logic [31:0] idleData = 32'h5a5a_a5a5;
  // one wait state, then a single-cycle answer; idle data toggles so no stale value survives
  always @(posedge clock) begin
    term <= '0;
    idleData <= ~idleData;
    term.data <= idleData;
    cnt <= bus.strobe ? cnt + 4'h1 : 4'h0;
    if (bus.strobe && cnt == 4'h1 && bus.space == SPACE_SPECIAL) begin
      // strobe may stay high into a second byte cycle, so each answer restarts the count
      cnt <= 4'h0;
      term.data <= (mode == 3'h5 && bus.addr[0]) ? {rdata[23:16], rdata[23:0]} : rdata;
      case (mode)
        3'h0: term.syncEnd <= 1'b1;
        3'h1: term.asyncAck <= 2'h2;
        3'h2: term.autovec <= 1'b1;
        3'h3: term.busFault <= 1'b1;
        3'h4: begin
          term.busFault <= !retried;
          term.halt <= !retried;
          term.autovec <= retried;
          retried <= !retried;
        end
        default: term.asyncAck <= ACK_BYTE;
      endcase
    end
  end
endmodule

// File: tb/csc_cpu_space_bench.sv
// testbench: special-space cycles against the far-side model
module csc_cpu_space_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import csc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] irqN = 3'h7;
  csc_req_t req = '0;
  csc_term_t term;
  csc_bus_t bus;
  csc_rsp_t rsp;
  logic busy;
  logic [2:0] mode = 3'h0;
  logic [31:0] rdata = 32'h4040_4040;
  int numErrors = 0;
  int cmpCount = 0;
  logic [2:0] bm [4] = '{3'h0, 3'h1, 3'h5, 3'h3};
  always #2 clock = ~clock;
  csc_cpu_space csc_cpu_space_inst (.clock(clock), .rst_n(rst_n), .irqPriorityInputs_n(irqN),
    .req(req), .term(term), .bus(bus), .rsp(rsp), .busy(busy));
  csc_far_model csc_far_model_inst (.clock(clock), .bus(bus), .mode(mode), .rdata(rdata),
    .term(term));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic testDone;
    $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // bounded wait on one output flag, looked at once the edge has settled
  task automatic waitFor(input int k);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (!(k == 0 ? bus.strobe : k == 1 ? rsp.vecValid :
      k == 2 ? (rsp.wordValid | rsp.illegal) : rsp.cpDone) && n < 40);
    chk(32'(n < 40), 32'h1);
  endtask
  task automatic tIrq(input logic [2:0] lvl, input logic [2:0] msk, input logic [2:0] md,
    input logic [7:0] expVec);
    @(negedge clock);
    mode = md;
    irqN = ~lvl;
    req.mask = msk;
    repeat (4) @(negedge clock);
    req.boundary = 1'b1;
    waitFor(0);
    chk(bus.addr, {12'hfff, TYPE_IACK, 12'hfff, lvl, 1'b1});
    @(negedge clock);
    req.boundary = 1'b0;
    irqN = 3'h7;
    waitFor(1);
    chk(32'(rsp.vector), 32'(expVec));
    chk(32'(rsp.level), 32'(lvl));
  endtask
  // level at or below mask, or a higher exception, must leave the bus quiet
  task automatic tBlock(input logic [2:0] lvl, input logic [2:0] msk, input logic hx);
    @(negedge clock);
    irqN = ~lvl;
    req.mask = msk;
    req.higherExc = hx;
    repeat (4) @(negedge clock);
    req.boundary = 1'b1;
    repeat (6) @(negedge clock);
    chk(32'(busy), 32'h0);
    req.boundary = 1'b0;
    req.higherExc = 1'b0;
    irqN = 3'h7;
  endtask
  task automatic tBkpt(input logic [2:0] num, input logic [2:0] md);
    @(negedge clock);
    mode = md;
    rdata = 32'ha5c3_3c5a;
    req.bkptNum = num;
    req.bkptGo = 1'b1;
    @(negedge clock);
    req.bkptGo = 1'b0;
    waitFor(0);
    chk(bus.addr, 32'({num, 2'b00}));
    waitFor(2);
    chk(32'({rsp.illegal, rsp.wordValid}), md == 3'h3 ? 32'h2 : 32'h1);
    if (md != 3'h3) chk(32'(rsp.word), 32'ha5c3);
  endtask
  task automatic tCp(input logic [2:0] id, input logic alt, input logic [2:0] md);
    @(negedge clock);
    mode = md;
    rdata = 32'h1234_5678;
    req.coproc_identity = id;
    req.cpReg = 5'h1f ^ 5'(id);
    req.altMove = alt;
    req.cpWrite = id[0];
    req.cpWdata = 32'hc0de_0000 | 32'(id);
    req.cpGo = 1'b1;
    @(negedge clock);
    req.cpGo = 1'b0;
    if (id == 3'h0 && !alt) begin
      repeat (4) @(negedge clock);
      chk(32'(busy), 32'h0);
    end else begin
      waitFor(0);
      chk(bus.addr, {12'h0, TYPE_COPROC, id, 8'h0, req.cpReg});
      chk(32'(bus.write), 32'(id[0]));
      if (id[0]) chk(bus.wdata, req.cpWdata);
      waitFor(3);
      chk(32'(rsp.cpFault), 32'(md == 3'h3));
      if (!id[0] && md != 3'h3) chk(rsp.cpData, rdata);
    end
  endtask
  initial begin
    #40000;
    numErrors++;
    testDone();
  end
  // autovectors for all seven levels, then vectored, spurious and retried acknowledges
  initial begin
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    for (int l = 1; l < 8; l++) tIrq(3'(l), l == 7 ? 3'h7 : 3'(l - 1), 3'h2, 8'(24 + l));
    tIrq(3'h3, 3'h0, 3'h0, 8'h40);
    tIrq(3'h6, 3'h2, 3'h1, 8'h40);
    tIrq(3'h2, 3'h1, 3'h3, 8'h18);
    tIrq(3'h5, 3'h0, 3'h4, 8'h1d);
    tBlock(3'h3, 3'h3, 1'b0);
    tBlock(3'h6, 3'h2, 1'b1);
    for (int n = 0; n < 8; n++) tBkpt(3'(n), bm[n % 4]);
    for (int i = 0; i < 8; i++) tCp(3'(i), 1'b0, 3'(i % 4));
    tCp(3'h0, 1'b1, 3'h0);
    testDone();
  end
endmodule
